// >>> hdl/aac_cfg_clock_div.sv
`timescale 1ns/1ps
`default_nettype none
module aac_cfg_clock_div
(
  input  wire logic ref_clk,
  input  wire logic rst,
  output var  logic cfgClk,
  output var  logic cfgFallEn
);

  logic [aac_pkg::CFG_DIV_W-1:0] cnt_q;
  logic [aac_pkg::CFG_DIV_W-1:0] cnt_d;
  logic                          clk_q;
  logic                          clk_d;
  logic                          fall_q;
  logic                          fall_d;

  // *****************************************************************
  // Divider
  // *****************************************************************
  // divide to slow clock
  always_comb
  begin
    if (cnt_q == aac_pkg::CFG_DIV_W'(aac_pkg::CFG_CLK_DIV - 1))
      cnt_d = '0;
    else
      cnt_d = cnt_q + aac_pkg::CFG_DIV_W'(1);
    clk_d  = (cnt_d < aac_pkg::CFG_DIV_W'(aac_pkg::CFG_CLK_HALF));
    fall_d = (cnt_d == aac_pkg::CFG_DIV_W'(aac_pkg::CFG_CLK_HALF));
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      // Parked on the last count to match the low clock, so the first
      // slow period after reset is full length and never too fast
      cnt_q  <= aac_pkg::CFG_DIV_W'(aac_pkg::CFG_CLK_DIV - 1);
      clk_q  <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      clk_q  <= clk_d;
      fall_q <= fall_d;
    end
  end

  assign cfgClk    = clk_q;
  assign cfgFallEn = fall_q;

endmodule
`default_nettype wire

// >>> hdl/aac_control_top.sv
`timescale 1ns/1ps
`default_nettype none
module aac_control_top
#(
  parameter int                             RESULT_SHIFT    = 0,
  parameter bit                             STRIP_INT_LOGIC = 1'b0,
  parameter logic [aac_pkg::STROBE_W-1:0]   GATE_DRIVER_CFG = 10'h3ff
)
(
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [aac_pkg::ADDR_W-1:0]    PADDR,
  input  wire logic [aac_pkg::DATA_W-1:0]    PWDATA,
  output var  logic [aac_pkg::DATA_W-1:0]    PRDATA,
  input  wire logic                          adcCalibrate,
  input  wire logic                          adcSample,
  input  wire logic                          adcBusy,
  input  wire logic                          resultValid,
  input  wire logic [aac_pkg::RESULT_W-1:0]  adcResult,
  input  wire logic                          counterMatchOutput,
  input  wire logic [aac_pkg::CFG_W-1:0]     cfgRdata,
  output var  logic                          interruptOut,
  output var  logic [aac_pkg::STROBE_W-1:0]  currentMonitorStrobes,
  output var  logic [aac_pkg::STROBE_W-1:0]  temperatureMonitorStrobes,
  output var  logic                          internalTempStrobe,
  output var  logic [aac_pkg::STROBE_W-1:0]  gateDriverEnables,
  output var  logic                          cfgClk,
  output var  logic [aac_pkg::CFG_W-1:0]     cfgAddr,
  output var  logic [aac_pkg::CFG_W-1:0]     cfgWdata,
  output var  logic                          cfgWriteStrobe,
  output var  logic                          cfgReadStrobe,
  output var  logic                          cfgResetStrobe
);

  // *****************************************************************
  // Declarations
  // *****************************************************************
  logic                          wrAccess;
  logic                          rdSetup;
  logic                          rdAccess;
  logic                          cfgFallEn;

  logic [aac_pkg::STROBE_W-1:0]  cmStrobe_q;
  logic [aac_pkg::STROBE_W-1:0]  cmStrobe_d;
  logic [aac_pkg::TEMP_W-1:0]    tmStrobe_q;
  logic [aac_pkg::TEMP_W-1:0]    tmStrobe_d;
  logic [aac_pkg::STROBE_W-1:0]  gdEnable_q;
  logic [aac_pkg::STROBE_W-1:0]  gdEnable_d;
  logic [aac_pkg::STROBE_W-1:0]  gdImpl;
  logic [aac_pkg::INT_W-1:0]     interrupt_enable_bits_q;
  logic [aac_pkg::INT_W-1:0]     interrupt_enable_bits_d;
  logic [aac_pkg::CFG_W-1:0]     cfgAddr_q;
  logic [aac_pkg::CFG_W-1:0]     cfgAddr_d;
  logic [aac_pkg::CFG_W-1:0]     cfgWdata_q;
  logic [aac_pkg::CFG_W-1:0]     cfgWdata_d;

  logic                          calPrev_q;
  logic                          busyPrev_q;
  logic                          validPrev_q;
  logic                          matchPrev_q;
  logic [aac_pkg::INT_W-1:0]     flags_q;
  logic [aac_pkg::INT_W-1:0]     flags_d;
  logic [aac_pkg::INT_W-1:0]     clrMask_q;
  logic [aac_pkg::INT_W-1:0]     clrMask_d;
  logic [aac_pkg::INT_W-1:0]     events;
  logic [aac_pkg::INT_W-1:0]     keepMask;
  logic                          irq_q;
  logic                          irq_d;

  aac_pkg::aac_cfg_state_t       cfgState_q;
  aac_pkg::aac_cfg_state_t       cfgState_d;
  logic                          armed_q;
  logic                          armed_d;
  logic                          cfgRd_q;
  logic                          cfgRd_d;
  logic                          cfgWr_q;
  logic                          cfgWr_d;
  logic                          cfgRst_q;
  logic                          cfgRst_d;
  logic [aac_pkg::CFG_W-1:0]     cfgRdData_q;
  logic [aac_pkg::CFG_W-1:0]     cfgRdData_d;
  logic                          cfgRdDone;
  logic                          cfgWrDone;

  logic [aac_pkg::RESULT_W-1:0]  shiftedResult;
  logic [aac_pkg::DATA_W-1:0]    rdValue;
  logic [aac_pkg::DATA_W-1:0]    prdata_q;
  logic [aac_pkg::DATA_W-1:0]    prdata_d;

  // *****************************************************************
  // Slow clock
  // *****************************************************************
  aac_cfg_clock_div u_clock_div
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cfgClk    (cfgClk),
    .cfgFallEn (cfgFallEn)
  );

  // *****************************************************************
  // Bus decode
  // *****************************************************************
  assign wrAccess = PSEL & PENABLE & PWRITE;
  assign rdSetup  = PSEL & ~PENABLE & ~PWRITE;
  assign rdAccess = PSEL & PENABLE & ~PWRITE;

  for (genvar g = 0; g < aac_pkg::STROBE_W; g++)
  begin : g_gate
    assign gdImpl[g] = GATE_DRIVER_CFG[g];
  end

  assign keepMask = STRIP_INT_LOGIC ? ~aac_pkg::INT_STRIP_MASK : {aac_pkg::INT_W{1'b1}};

  // *****************************************************************
  // Control registers
  // *****************************************************************
  always_comb
  begin
    cmStrobe_d = cmStrobe_q;
    tmStrobe_d = tmStrobe_q;
    gdEnable_d = gdEnable_q;
    interrupt_enable_bits_d    = interrupt_enable_bits_q;
    cfgAddr_d  = cfgAddr_q;
    cfgWdata_d = cfgWdata_q;
    if (wrAccess)
    begin
      case (PADDR)
        aac_pkg::ADDR_CUR_STROBE:  cmStrobe_d = PWDATA[aac_pkg::STROBE_W-1:0];
        aac_pkg::ADDR_TEMP_STROBE: tmStrobe_d = PWDATA[aac_pkg::TEMP_W-1:0];
        aac_pkg::ADDR_GATE_EN:     gdEnable_d = PWDATA[aac_pkg::STROBE_W-1:0] & gdImpl;
        aac_pkg::ADDR_INT_MASK:    interrupt_enable_bits_d = PWDATA[aac_pkg::INT_W-1:0] & keepMask;
        aac_pkg::ADDR_CFG_ADDR:    cfgAddr_d = PWDATA[aac_pkg::CFG_W-1:0];
        aac_pkg::ADDR_CFG_DATA:
        begin
          // Writes are dropped while a cycle is in flight
          if (cfgState_q == aac_pkg::CFG_IDLE)
            cfgWdata_d = PWDATA[aac_pkg::CFG_W-1:0];
        end
        default:                   cmStrobe_d = cmStrobe_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cmStrobe_q <= aac_pkg::STROBE_RESET;
      tmStrobe_q <= aac_pkg::TEMP_RESET;
      gdEnable_q <= aac_pkg::STROBE_RESET;
      interrupt_enable_bits_q    <= aac_pkg::INT_RESET;
      cfgAddr_q  <= aac_pkg::CFG_RESET_V;
      cfgWdata_q <= aac_pkg::CFG_RESET_V;
    end
    else
    begin
      cmStrobe_q <= cmStrobe_d;
      tmStrobe_q <= tmStrobe_d;
      gdEnable_q <= gdEnable_d;
      interrupt_enable_bits_q    <= interrupt_enable_bits_d;
      cfgAddr_q  <= cfgAddr_d;
      cfgWdata_q <= cfgWdata_d;
    end
  end

  // *****************************************************************
  // Configuration cycle sequencer
  // *****************************************************************
  // Strobes change one fast cycle after the slow clock falls, so they
  // are stable for a whole slow period around its rising edge.
  always_comb
  begin
    cfgState_d  = cfgState_q;
    armed_d     = armed_q;
    cfgRdData_d = cfgRdData_q;
    cfgRdDone   = 1'b0;
    cfgWrDone   = 1'b0;
    case (cfgState_q)
      aac_pkg::CFG_IDLE:
      begin
        armed_d = 1'b0;
        if (wrAccess && PADDR == aac_pkg::ADDR_CFG_DATA)
          cfgState_d = aac_pkg::CFG_WRITE;
        else if (wrAccess && PADDR == aac_pkg::ADDR_CFG_CTRL)
        begin
          if (PWDATA[aac_pkg::CTRL_RESET_BIT])
            cfgState_d = aac_pkg::CFG_RESET;
          else if (PWDATA[aac_pkg::CTRL_RD_START_BIT])
            cfgState_d = aac_pkg::CFG_READ;
        end
      end
      aac_pkg::CFG_RESET,
      aac_pkg::CFG_READ,
      aac_pkg::CFG_WRITE:
      begin
        if (cfgFallEn)
        begin
          if (!armed_q)
            armed_d = 1'b1;
          else
          begin
            armed_d    = 1'b0;
            cfgState_d = aac_pkg::CFG_IDLE;
            if (cfgState_q == aac_pkg::CFG_READ)
            begin
              cfgRdData_d = cfgRdata;
              cfgRdDone   = 1'b1;
            end
            if (cfgState_q == aac_pkg::CFG_WRITE)
              cfgWrDone = 1'b1;
          end
        end
      end
      default:
      begin
        cfgState_d = aac_pkg::CFG_IDLE;
        armed_d    = 1'b0;
      end
    endcase
    cfgRd_d  = armed_d && (cfgState_d == aac_pkg::CFG_READ);
    cfgWr_d  = armed_d && (cfgState_d == aac_pkg::CFG_WRITE);
    cfgRst_d = armed_d && (cfgState_d == aac_pkg::CFG_RESET);
  end

  always_ff @(posedge ref_clk)
  begin
    // A reset cycle runs after every reset release
    if (rst)
    begin
      cfgState_q  <= aac_pkg::CFG_RESET;
      armed_q     <= 1'b0;
      cfgRd_q     <= 1'b0;
      cfgWr_q     <= 1'b0;
      cfgRst_q    <= 1'b0;
      cfgRdData_q <= aac_pkg::CFG_RESET_V;
    end
    else
    begin
      cfgState_q  <= cfgState_d;
      armed_q     <= armed_d;
      cfgRd_q     <= cfgRd_d;
      cfgWr_q     <= cfgWr_d;
      cfgRst_q    <= cfgRst_d;
      cfgRdData_q <= cfgRdData_d;
    end
  end

  // *****************************************************************
  // Interrupt flags
  // *****************************************************************
  always_comb
  begin
    events = aac_pkg::INT_RESET;
    events[aac_pkg::INT_CAL_START]  = adcCalibrate & ~calPrev_q;
    events[aac_pkg::INT_CAL_END]    = ~adcCalibrate & calPrev_q;
    events[aac_pkg::INT_CONV_START] = adcBusy & ~busyPrev_q;
    events[aac_pkg::INT_VALID_RISE] = resultValid & ~validPrev_q;
    events[aac_pkg::INT_CFG_WR]     = cfgWrDone;
    events[aac_pkg::INT_CFG_RD]     = cfgRdDone;
    events[aac_pkg::INT_MATCH]      = counterMatchOutput & ~matchPrev_q;

    // Only bits seen by the read are cleared, later arrivals survive
    clrMask_d = rdSetup && PADDR == aac_pkg::ADDR_INT_FLAGS ? flags_q : aac_pkg::INT_RESET;
    if (rdAccess && PADDR == aac_pkg::ADDR_INT_FLAGS)
      flags_d = (flags_q & ~clrMask_q) | events;
    else
      flags_d = flags_q | events;
    flags_d = flags_d & keepMask;
    irq_d = |(flags_q & interrupt_enable_bits_q);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      calPrev_q   <= 1'b0;
      busyPrev_q  <= 1'b0;
      validPrev_q <= 1'b0;
      matchPrev_q <= 1'b0;
      flags_q     <= aac_pkg::INT_RESET;
      clrMask_q   <= aac_pkg::INT_RESET;
      irq_q       <= 1'b0;
    end
    else
    begin
      calPrev_q   <= adcCalibrate;
      busyPrev_q  <= adcBusy;
      validPrev_q <= resultValid;
      matchPrev_q <= counterMatchOutput;
      flags_q     <= flags_d;
      clrMask_q   <= clrMask_d;
      irq_q       <= irq_d;
    end
  end

  // *****************************************************************
  // Read data
  // *****************************************************************
  // result shift
  always_comb
  begin
    case (RESULT_SHIFT)
      2:       shiftedResult = {2'h0, adcResult[aac_pkg::RESULT_W-1:2]};
      4:       shiftedResult = {4'h0, adcResult[aac_pkg::RESULT_W-1:4]};
      default: shiftedResult = adcResult;
    endcase
  end

  always_comb
  begin
    rdValue = aac_pkg::REG_RESET;
    case (PADDR)
      aac_pkg::ADDR_CFG_CTRL:
      begin
        rdValue[aac_pkg::CTRL_RST_BUSY_BIT] = (cfgState_q == aac_pkg::CFG_RESET);
        rdValue[aac_pkg::CTRL_RD_BUSY_BIT]  = (cfgState_q == aac_pkg::CFG_READ);
        rdValue[aac_pkg::CTRL_WR_BUSY_BIT]  = (cfgState_q == aac_pkg::CFG_WRITE);
      end
      aac_pkg::ADDR_CFG_ADDR:    rdValue[aac_pkg::CFG_W-1:0] = cfgAddr_q;
      aac_pkg::ADDR_CFG_DATA:    rdValue[aac_pkg::CFG_W-1:0] = cfgRdData_q;
      aac_pkg::ADDR_CUR_STROBE:  rdValue[aac_pkg::STROBE_W-1:0] = cmStrobe_q;
      aac_pkg::ADDR_TEMP_STROBE: rdValue[aac_pkg::TEMP_W-1:0] = tmStrobe_q;
      aac_pkg::ADDR_GATE_EN:     rdValue[aac_pkg::STROBE_W-1:0] = gdEnable_q;
      aac_pkg::ADDR_CONV_STATUS:
      begin
        rdValue[aac_pkg::STAT_CAL_BIT]    = adcCalibrate;
        rdValue[aac_pkg::STAT_SAMPLE_BIT] = adcSample;
        rdValue[aac_pkg::STAT_BUSY_BIT]   = adcBusy;
        rdValue[aac_pkg::STAT_VALID_BIT]  = resultValid;
        rdValue[aac_pkg::RESULT_W-1:0]    = shiftedResult;
      end
      aac_pkg::ADDR_INT_MASK:    rdValue[aac_pkg::INT_W-1:0] = interrupt_enable_bits_q;
      aac_pkg::ADDR_INT_FLAGS:   rdValue[aac_pkg::INT_W-1:0] = flags_q;
      default:                   rdValue = aac_pkg::REG_RESET;
    endcase
    // Captured in setup so the access phase sees a registered value
    prdata_d = rdSetup ? rdValue : prdata_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prdata_q <= aac_pkg::REG_RESET;
    else
      prdata_q <= prdata_d;
  end

  // *****************************************************************
  // Outputs
  // *****************************************************************
  assign PRDATA                    = prdata_q;
  assign interruptOut              = irq_q;
  assign currentMonitorStrobes     = cmStrobe_q;
  assign temperatureMonitorStrobes = tmStrobe_q[aac_pkg::STROBE_W-1:0];
  assign internalTempStrobe        = tmStrobe_q[aac_pkg::TEMP_INT_BIT];
  assign gateDriverEnables         = gdEnable_q;
  assign cfgAddr                   = cfgAddr_q;
  assign cfgWdata                  = cfgWdata_q;
  assign cfgWriteStrobe            = cfgWr_q;
  assign cfgReadStrobe             = cfgRd_q;
  assign cfgResetStrobe            = cfgRst_q;

endmodule
`default_nettype wire

// >>> hdl/aac_pkg.sv
package aac_pkg;

  // *****************************************************************
  // Clocking
  // *****************************************************************
  localparam int PCLK_FREQ_MHZ   = 250;
  localparam int CFG_CLK_MAX_MHZ = 10;
  // Rounded up so the slow clock never exceeds its limit
  localparam int CFG_CLK_DIV     = (PCLK_FREQ_MHZ + CFG_CLK_MAX_MHZ - 1) / CFG_CLK_MAX_MHZ;
  localparam int CFG_CLK_HALF    = CFG_CLK_DIV / 2;
  localparam int CFG_DIV_W       = $clog2(CFG_CLK_DIV);

  // *****************************************************************
  // Widths
  // *****************************************************************
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 16;
  localparam int STROBE_W = 10;
  localparam int TEMP_W   = 11;
  localparam int CFG_W    = 8;
  localparam int RESULT_W = 12;
  localparam int INT_W    = 7;

  // *****************************************************************
  // Register offsets
  // *****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CFG_CTRL    = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_CFG_ADDR    = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_CFG_DATA    = 7'h08;
  localparam logic [ADDR_W-1:0] ADDR_CUR_STROBE  = 7'h14;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_STROBE = 7'h18;
  localparam logic [ADDR_W-1:0] ADDR_GATE_EN     = 7'h1c;
  localparam logic [ADDR_W-1:0] ADDR_CONV_STATUS = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK    = 7'h2c;
  localparam logic [ADDR_W-1:0] ADDR_INT_FLAGS   = 7'h30;

  // *****************************************************************
  // Field positions
  // *****************************************************************
  localparam int CTRL_RESET_BIT    = 0;
  localparam int CTRL_RD_START_BIT = 1;
  localparam int CTRL_RST_BUSY_BIT = 2;
  localparam int CTRL_RD_BUSY_BIT  = 3;
  localparam int CTRL_WR_BUSY_BIT  = 4;
  localparam int TEMP_INT_BIT      = 10;
  localparam int STAT_CAL_BIT      = 15;
  localparam int STAT_SAMPLE_BIT   = 14;
  localparam int STAT_BUSY_BIT     = 13;
  localparam int STAT_VALID_BIT    = 12;

  localparam int INT_CAL_START  = 0;
  localparam int INT_CAL_END    = 1;
  localparam int INT_CONV_START = 2;
  localparam int INT_VALID_RISE = 3;
  localparam int INT_CFG_WR     = 4;
  localparam int INT_CFG_RD     = 5;
  localparam int INT_MATCH      = 6;

  // Bits removed by the strip option
  localparam logic [INT_W-1:0] INT_STRIP_MASK = 7'h4f;

  // *****************************************************************
  // Reset values
  // *****************************************************************
  localparam logic [DATA_W-1:0]   REG_RESET    = 16'h0000;
  localparam logic [STROBE_W-1:0] STROBE_RESET = 10'h000;
  localparam logic [TEMP_W-1:0]   TEMP_RESET   = 11'h000;
  localparam logic [INT_W-1:0]    INT_RESET    = 7'h00;
  localparam logic [CFG_W-1:0]    CFG_RESET_V  = 8'h00;

  typedef enum logic [1:0] {
    CFG_IDLE  = 2'b00,
    CFG_RESET = 2'b01,
    CFG_READ  = 2'b10,
    CFG_WRITE = 2'b11
  } aac_cfg_state_t;

endpackage

// >>> tb/aac_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aac_control_chk
#(
  parameter int         RESULT_SHIFT    = 0,
  parameter logic [9:0] GATE_DRIVER_CFG = 10'h3ff
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [6:0]  PADDR,
  input wire logic [15:0] PWDATA,
  input wire logic [15:0] PRDATA,
  input wire logic        adcCalibrate,
  input wire logic [11:0] adcResult,
  input wire logic        interruptOut,
  input wire logic [9:0]  currentMonitorStrobes,
  input wire logic [9:0]  temperatureMonitorStrobes,
  input wire logic        internalTempStrobe,
  input wire logic [9:0]  gateDriverEnables,
  input wire logic        cfgClk,
  input wire logic        cfgWriteStrobe,
  input wire logic        cfgReadStrobe,
  input wire logic        cfgResetStrobe
);
  // ****************
  // Checks
  // ****************
  wire logic wrAcc  = PSEL && PENABLE && PWRITE;
  wire logic stRd   = PSEL && !PENABLE && !PWRITE && PADDR == 7'h20;
  wire logic cfgStb = cfgWriteStrobe || cfgReadStrobe || cfgResetStrobe;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_cur_strobe_map:
    assert property (wrAcc && PADDR == 7'h14 |=> currentMonitorStrobes == $past(PWDATA[9:0]))
    else $error("cur strobes");
  a_temp_strobe_map:
    assert property (wrAcc && PADDR == 7'h18 |=>
      {internalTempStrobe, temperatureMonitorStrobes} == $past(PWDATA[10:0]))
    else $error("temp strobes");
  a_gate_enable_map:
    assert property (wrAcc && PADDR == 7'h1c |=>
      gateDriverEnables == ($past(PWDATA[9:0]) & GATE_DRIVER_CFG))
    else $error("gate enables");
  // Only steady inputs, so the setup cycle in which PRDATA is captured cannot matter
  a_cal_status_bit:
    assert property (stRd && $stable(adcCalibrate) |=> PRDATA[15] == $past(adcCalibrate))
    else $error("cal status");
  a_result_field_shift:
    assert property (stRd && $stable(adcResult) |=>
      PRDATA[11:0] == ($past(adcResult) >> RESULT_SHIFT))
    else $error("result field");
  a_slow_clk_high:
    assert property ($rose(cfgClk) |-> ##11 cfgClk ##1 !cfgClk)
    else $error("slow clock high");
  a_slow_clk_low:
    assert property ($fell(cfgClk) |-> ##12 !cfgClk ##1 cfgClk)
    else $error("slow clock low");
  a_cfg_strobe_len:
    assert property ($rose(cfgStb) |-> !cfgClk ##24 cfgStb ##1 !cfgStb)
    else $error("config strobe");
  c_int: cover property ($rose(interruptOut));
  c_wr: cover property ($rose(cfgWriteStrobe));
  c_rd: cover property ($rose(cfgReadStrobe));
endmodule
bind aac_control_top aac_control_chk #(.RESULT_SHIFT(RESULT_SHIFT), .GATE_DRIVER_CFG(GATE_DRIVER_CFG))
  u_chk (.*);
`default_nettype wire

// >>> tb/aac_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aac_control_tb;
  typedef struct packed {logic [6:0] a; logic [15:0] d; logic [15:0] r; logic [30:0] o;} aac_row_t;
  // Address, write data, readback, {gate, temp int, temp, cur}
  aac_row_t    rows [7] = '{
    '{7'h14, 16'hffff, 16'h03ff, 31'h0000_03ff},
    '{7'h18, 16'hffff, 16'h07ff, 31'h001f_ffff},
    '{7'h1c, 16'hffff, 16'h03ff, 31'h7fff_ffff},
    '{7'h14, 16'h0155, 16'h0155, 31'h7fff_fd55},
    '{7'h2c, 16'hffff, 16'h007f, 31'h7fff_fd55},
    '{7'h20, 16'hffff, 16'h0000, 31'h7fff_fd55},
    '{7'h50, 16'hffff, 16'h0000, 31'h7fff_fd55}};
  logic        ref_clk = 1'b0, rst = 1'b1, pSel = 1'b0, pEn = 1'b0, pWr = 1'b0;
  logic        cal = 1'b0, smp = 1'b0, busy = 1'b0, vld = 1'b0, match = 1'b0;
  logic [6:0]  pAddr = 7'h00;
  logic [15:0] pWdata = 16'h0000, v, pRdata;
  logic [11:0] res = 12'h000;
  logic [9:0]  cur, tmp, gate;
  logic        tmpInt, intOut, cfgClk, cfgWr, cfgRd;
  logic [7:0]  cfgAddr, cfgWdata, cfgRdata;
  int          errCount = 0, totalChecks = 0, cycles = 0;
  aac_control_top u_dut (.ref_clk(ref_clk), .rst(rst), .PSEL(pSel), .PENABLE(pEn), .PWRITE(pWr),
    .PADDR(pAddr), .PWDATA(pWdata), .PRDATA(pRdata), .adcCalibrate(cal), .adcSample(smp),
    .adcBusy(busy), .resultValid(vld), .adcResult(res), .counterMatchOutput(match),
    .cfgRdata(cfgRdata), .interruptOut(intOut), .currentMonitorStrobes(cur),
    .temperatureMonitorStrobes(tmp), .internalTempStrobe(tmpInt), .gateDriverEnables(gate),
    .cfgClk(cfgClk), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgWriteStrobe(cfgWr),
    .cfgReadStrobe(cfgRd), .cfgResetStrobe());
  aac_macro_model u_macro (.cfgClk(cfgClk), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
    .cfgWriteStrobe(cfgWr), .cfgReadStrobe(cfgRd), .cfgRdata(cfgRdata));
  // ****************
  // Helpers
  // ****************
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errCount++;
      $display("BAD %0t timeout", $time);
      reportAndStop();
    end
  end
  // Idle cycle after each access so no strobe is set twice in one step
  task automatic apb(input logic w, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    pSel <= 1'b1;
    pWr <= w;
    pAddr <= a;
    pWdata <= d;
    @(posedge ref_clk);
    pEn <= 1'b1;
    @(posedge ref_clk);
    q = pRdata;
    pSel <= 1'b0;
    pEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle;
    v = 16'hffff;
    while (v !== 16'h0000)
      apb(1'b0, 7'h00, 16'h0000, v);
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 7'h00, 16'h0000, v);
    chk(32'(v), 32'h0000_0004);
    $display("reset test done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d, v);
      apb(1'b0, rows[i].a, 16'h0000, v);
      chk(32'(v), 32'(rows[i].r));
      chk(32'({gate, tmpInt, tmp, cur}), 32'(rows[i].o));
    end
    $display("row test done");
    cal <= 1'b1;
    smp <= 1'b1;
    vld <= 1'b1;
    res <= 12'habc;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, 7'h20, 16'h0000, v);
    chk(32'(v), 32'h0000_dabc);
    cal <= 1'b0;
    busy <= 1'b1;
    match <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(intOut), 32'h0000_0001);
    apb(1'b0, 7'h30, 16'h0000, v);
    chk(32'(v), 32'h0000_004f);
    apb(1'b0, 7'h30, 16'h0000, v);
    chk(32'(v), 32'h0000_0000);
    chk(32'(intOut), 32'h0000_0000);
    apb(1'b1, 7'h2c, 16'h0000, v);
    match <= 1'b0;
    @(posedge ref_clk);
    match <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(intOut), 32'h0000_0000);
    apb(1'b0, 7'h30, 16'h0000, v);
    chk(32'(v), 32'h0000_0040);
    apb(1'b0, 7'h20, 16'h0000, v);
    chk(32'(v), 32'h0000_7abc);
    vld <= 1'b0;
    @(posedge ref_clk);
    // Valid rise lands on the access edge of the clearing read
    fork
      apb(1'b0, 7'h30, 16'h0000, v);
      begin
        @(posedge ref_clk);
        vld <= 1'b1;
      end
    join
    chk(32'(v), 32'h0000_0000);
    apb(1'b0, 7'h30, 16'h0000, v);
    chk(32'(v), 32'h0000_0008);
    $display("flag test done");
    idle();
    apb(1'b1, 7'h04, 16'h0058, v);
    apb(1'b1, 7'h08, 16'h005a, v);
    apb(1'b0, 7'h00, 16'h0000, v);
    chk(32'(v), 32'h0000_0010);
    idle();
    apb(1'b1, 7'h00, 16'h0002, v);
    idle();
    apb(1'b0, 7'h08, 16'h0000, v);
    chk(32'(v), 32'h0000_005a);
    apb(1'b0, 7'h30, 16'h0000, v);
    chk(32'(v), 32'h0000_0030);
    $display("config test done");
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(32'({gate, tmpInt, tmp, cur}), 32'h0000_0000);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 7'h00, 16'h0000, v);
    chk(32'(v), 32'h0000_0004);
    $display("second reset test done");
    reportAndStop();
  end
endmodule
`default_nettype wire

// >>> tb/aac_macro_model.sv
`timescale 1ns/1ps
`default_nettype none
module aac_macro_model
(
  input  wire logic       cfgClk,
  input  wire logic [7:0] cfgAddr,
  input  wire logic [7:0] cfgWdata,
  input  wire logic       cfgWriteStrobe,
  input  wire logic       cfgReadStrobe,
  output var  logic [7:0] cfgRdata
);
  // ****************
  // Config bytes
  // ****************
  logic [7:0] cell_q [256];
  logic [7:0] rdData_q = 8'h00;
  // Macro acts only on the slow clock, as the real one does
  always @(posedge cfgClk)
  begin
    if (cfgWriteStrobe)
      cell_q[cfgAddr] <= cfgWdata;
    // data window
    // Churns when not read so a late capture is caught
    if (cfgReadStrobe)
      rdData_q <= cell_q[cfgAddr];
    else
      rdData_q <= ~rdData_q;
  end
  assign cfgRdata = rdData_q;
endmodule
`default_nettype wire
